// [rtl/lockout_recovery_map.vh]
// Constants for the flash lockout recovery block
`ifndef LOCKOUT_RECOVERY_MAP_VH
`define LOCKOUT_RECOVERY_MAP_VH
`define LR_IR_WIDTH        4
`define LR_IR_RECOVERY     4'hB
`define LR_IR_IDCODE       4'h2
`define LR_IR_CORE_DEBUG   4'h7
`define LR_IR_BYPASS       4'hF
`define LR_DIV_WIDTH       7
`define LR_DIV_RESET       7'h00
// Arbitrary identification value
`define LR_IDCODE          32'h1234A5A5
`define LR_SEC_ADDR        16'h7FF7
`define LR_SEC_SECURED     16'h0002
`define LR_SEC_CLEAR       16'h0000
`define LR_ERASED_WORD     16'hFFFF
`define LR_WORD_WIDTH      16
`define LR_ADDR_WIDTH      16
`endif

// [rtl/flash_lockout_recovery_jtag.v]
// JTAG TAP with lockout recovery, security latch and flash access gating
`timescale 1ns/1ps
`include "lockout_recovery_map.vh"

// Functional notes
// R1 - Recovery mass-erases whole flash including configuration field, clearing security.
// R2 - Security drops only at next reset after the erase completes.
// R3 - Host first loads the recovery instruction into the TAP instruction register.
// R4 - Host then shifts a 7-bit erase clock divider into its data register.
// R5 - Erase begins on entry to Run-Test/Idle after the divider update.
// R6 - Host stays in Run-Test/Idle until the erase finishes.
// R7 - Host resets TAP and device after recovery for unsecured operation.
// R8 - Power-on reset clears both the TAP and the device logic.
// R9 - Firmware writing zero into the security word unsecures the device.
// R10 - After reprogramming the word, TAP and device must both be reset.
// R11 - Programming clears bits only; setting a bit back needs an erase.
// R12 - Application supplies its own trigger for the reprogramming routine.
// R13 - Security word equal to two means secured, kept through reset.
// R14 - While secured, core debug flash access is blocked; scan and ID stay.
module flash_lockout_recovery_jtag (
   input  wire        clk_i,
   input  wire        rstn_i,
   input  wire        tck_i,
   input  wire        tms_i,
   input  wire        tdi_i,
   input  wire        trstn_i,
   output reg         tdo_o,
   output reg         tdo_oe_n_o,
   input  wire [15:0] sec_word_i,
   input  wire        fw_prog_i,
   input  wire [15:0] fw_addr_i,
   input  wire [15:0] fw_data_i,
   input  wire        dbg_req_i,
   output reg         dbg_grant_o,
   input  wire        flash_done_i,
   output reg         flash_mass_erase_o,
   output reg  [6:0]  flash_erase_div_o,
   output reg         flash_prog_o,
   output reg  [15:0] flash_addr_o,
   output reg  [15:0] flash_data_o,
   output reg         secured_o,
   output reg         erase_busy_o,
   output reg         erase_done_o
);

   // ****************************************
   // TAP state machine
   // ****************************************
   localparam [3:0] S_RESET = 4'h0, S_IDLE = 4'h1, S_SEL_DR = 4'h2, S_CAP_DR = 4'h3,
                    S_SH_DR = 4'h4, S_EX1_DR = 4'h5, S_PA_DR = 4'h6, S_EX2_DR = 4'h7,
                    S_UP_DR = 4'h8, S_SEL_IR = 4'h9, S_CAP_IR = 4'hA, S_SH_IR = 4'hB,
                    S_EX1_IR = 4'hC, S_PA_IR = 4'hD, S_EX2_IR = 4'hE, S_UP_IR = 4'hF;

   // TCK sampled as a plain input; edges found in the system clock.
   // Limitation: TCK high and low must each last at least one clk_i period,
   // or an edge is missed and the TAP falls out of step with the host.
   reg                        tck_q;
   reg  [3:0]                 state;
   reg  [3:0]                 next_state;
   reg  [`LR_IR_WIDTH-1:0]    ir_sh;
   reg  [`LR_IR_WIDTH-1:0]    ir;
   reg  [31:0]                dr_sh;
   reg  [`LR_DIV_WIDTH-1:0]   div;
   reg                        div_loaded;
   reg                        erase_started;
   reg                        erase_complete;
   reg                        tdo_next;
   wire                       tck_rise = tck_i & ~tck_q;
   wire                       tck_fall = ~tck_i & tck_q;

   always @* begin
      case (state)
         S_RESET:  next_state = tms_i ? S_RESET  : S_IDLE;
         S_IDLE:   next_state = tms_i ? S_SEL_DR : S_IDLE;
         S_SEL_DR: next_state = tms_i ? S_SEL_IR : S_CAP_DR;
         S_CAP_DR: next_state = tms_i ? S_EX1_DR : S_SH_DR;
         S_SH_DR:  next_state = tms_i ? S_EX1_DR : S_SH_DR;
         S_EX1_DR: next_state = tms_i ? S_UP_DR  : S_PA_DR;
         S_PA_DR:  next_state = tms_i ? S_EX2_DR : S_PA_DR;
         S_EX2_DR: next_state = tms_i ? S_UP_DR  : S_SH_DR;
         S_UP_DR:  next_state = tms_i ? S_SEL_DR : S_IDLE;
         S_SEL_IR: next_state = tms_i ? S_RESET  : S_CAP_IR;
         S_CAP_IR: next_state = tms_i ? S_EX1_IR : S_SH_IR;
         S_SH_IR:  next_state = tms_i ? S_EX1_IR : S_SH_IR;
         S_EX1_IR: next_state = tms_i ? S_UP_IR  : S_PA_IR;
         S_PA_IR:  next_state = tms_i ? S_EX2_IR : S_PA_IR;
         S_EX2_IR: next_state = tms_i ? S_UP_IR  : S_SH_IR;
         S_UP_IR:  next_state = tms_i ? S_SEL_DR : S_IDLE;
         default:  next_state = S_RESET;
      endcase
   end

   always @* begin
      if (state == S_SH_IR)
         tdo_next = ir_sh[0];
      else
         tdo_next = dr_sh[0];
   end

   // ****************************************
   // TAP registers
   // ****************************************
   always @(posedge clk_i or negedge rstn_i) begin // see R8
      if (!rstn_i) begin
         tck_q      <= 1'b0;
         state      <= S_RESET;
         ir_sh      <= `LR_IR_BYPASS;
         ir         <= `LR_IR_IDCODE;
         dr_sh      <= 32'h00000000;
         div        <= `LR_DIV_RESET;
         div_loaded <= 1'b0;
         tdo_o      <= 1'b0;
         tdo_oe_n_o <= 1'b1;
      end else begin
         tck_q <= tck_i;
         if (!trstn_i) begin
            state      <= S_RESET;
            ir         <= `LR_IR_IDCODE;
            div_loaded <= 1'b0;
            tdo_oe_n_o <= 1'b1;
         end else if (tck_rise) begin
            state <= next_state;
            case (state)
               S_RESET: begin
                  ir         <= `LR_IR_IDCODE;
                  div_loaded <= 1'b0;
               end
               S_CAP_IR: ir_sh <= 4'h1;
               S_SH_IR:  ir_sh <= {tdi_i, ir_sh[`LR_IR_WIDTH-1:1]};
               S_UP_IR: begin
                  ir         <= ir_sh; // see R3
                  div_loaded <= 1'b0;
               end
               S_CAP_DR: begin
                  if (ir == `LR_IR_IDCODE)
                     dr_sh <= `LR_IDCODE; // see R14
                  else if (ir == `LR_IR_RECOVERY)
                     dr_sh <= {25'h0000000, div};
                  else
                     dr_sh <= 32'h00000000;
               end
               S_SH_DR: begin
                  if (ir == `LR_IR_RECOVERY)
                     dr_sh <= {25'h0000000, tdi_i, dr_sh[`LR_DIV_WIDTH-1:1]}; // see R4
                  else if (ir == `LR_IR_IDCODE)
                     dr_sh <= {tdi_i, dr_sh[31:1]};
                  else
                     dr_sh <= {31'h00000000, tdi_i};
               end
               S_UP_DR: begin
                  if (ir == `LR_IR_RECOVERY) begin
                     div        <= dr_sh[`LR_DIV_WIDTH-1:0]; // see R4
                     div_loaded <= 1'b1;
                  end
               end
               default: ;
            endcase
         end else if (tck_fall) begin
            tdo_o      <= tdo_next;
            tdo_oe_n_o <= ~((state == S_SH_IR) | (state == S_SH_DR));
         end
      end
   end

   // ****************************************
   // Mass erase and security latch
   // ****************************************
   // Security is latched from the stored word only at reset release, so a
   // completed erase or reprogram takes effect after the next reset.
   // Read once, so a later change of the word cannot unlock mid-run.
   reg        sec_loaded;
   wire       in_idle = (state == S_IDLE);
   wire       erase_go = div_loaded & in_idle & (ir == `LR_IR_RECOVERY) & ~erase_started;

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sec_loaded         <= 1'b0;
         secured_o          <= 1'b1;
         erase_started      <= 1'b0;
         erase_complete     <= 1'b0;
         flash_mass_erase_o <= 1'b0;
         flash_erase_div_o  <= `LR_DIV_RESET;
         erase_busy_o       <= 1'b0;
         erase_done_o       <= 1'b0;
         dbg_grant_o        <= 1'b0;
         flash_prog_o       <= 1'b0;
         flash_addr_o       <= 16'h0000;
         flash_data_o       <= 16'h0000;
      end else begin
         if (!sec_loaded) begin
            sec_loaded <= 1'b1;
            secured_o  <= (sec_word_i == `LR_SEC_SECURED); // see R13 R2 R9
         end
         if (erase_go) begin
            erase_started      <= 1'b1; // see R5
            flash_mass_erase_o <= 1'b1; // see R1
            flash_erase_div_o  <= div;
            erase_busy_o       <= 1'b1;
         end else if (erase_busy_o & flash_done_i) begin
            flash_mass_erase_o <= 1'b0;
            erase_busy_o       <= 1'b0;
            erase_complete     <= 1'b1;
         end else if (erase_busy_o & ~in_idle) begin
            // Leaving idle early aborts; flash stays secured until a new run
            // Divider stays loaded, so re-entering idle from Update-DR restarts the erase
            flash_mass_erase_o <= 1'b0; // see R6
            erase_busy_o       <= 1'b0;
            erase_started      <= 1'b0;
         end
         erase_done_o <= erase_complete | (erase_busy_o & flash_done_i);
         if (!in_idle & ~erase_busy_o)
            erase_started <= erase_complete;
         dbg_grant_o  <= dbg_req_i & ~secured_o & ~erase_busy_o & (ir == `LR_IR_CORE_DEBUG); // see R14
         // Programming only clears bits; the flash array ANDs the data in
         flash_prog_o <= fw_prog_i & ~erase_busy_o; // see R11 R12
         flash_addr_o <= fw_addr_i;
         flash_data_o <= fw_data_i;
      end
   end

endmodule // flash_lockout_recovery_jtag

// [tb/lockout_props.sv]
// Assertions on the ports of the lockout recovery block
`timescale 1ns/1ps
`include "lockout_recovery_map.vh"
module lockout_props (
   input wire        clk_i,
   input wire        rstn_i,
   input wire [15:0] sec_word_i,
   input wire        fw_prog_i,
   input wire [15:0] fw_addr_i,
   input wire [15:0] fw_data_i,
   input wire        dbg_grant_o,
   input wire        flash_done_i,
   input wire        flash_mass_erase_o,
   input wire [6:0]  flash_erase_div_o,
   input wire        flash_prog_o,
   input wire [15:0] flash_addr_o,
   input wire [15:0] flash_data_o,
   input wire        secured_o,
   input wire        erase_busy_o,
   input wire        erase_done_o
);
   // ****************
   // Properties
   // ****************
   // Edges since reset; the latch loads on the first one
   reg [1:0] up;
   always @(posedge clk_i or negedge rstn_i)
      if (!rstn_i) up <= 2'h0;
      else if (up != 2'h3) up <= up + 2'h1;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_finish; flash_mass_erase_o && flash_done_i; endsequence
   sequence s_closed; !flash_mass_erase_o && erase_done_o && !erase_busy_o; endsequence
   a_erase_closes: assert property (s_finish |=> s_closed)
      else $error("erase did not close");
   a_done_stands: assert property (erase_done_o |=> erase_done_o)
      else $error("done dropped");
   a_secure_holds: assert property (up == 2'h3 && secured_o |=> secured_o)
      else $error("security dropped without reset");
   a_secure_load: assert property (up == 2'h1 |->
      secured_o == ($past(sec_word_i) == `LR_SEC_SECURED))
      else $error("security latch wrong");
   a_reset_clean: assert property (up == 2'h1 |->
      !flash_mass_erase_o && !erase_done_o && !flash_prog_o)
      else $error("state left after reset");
   a_secure_blocks: assert property (secured_o |-> !dbg_grant_o)
      else $error("grant while secured");
   a_busy_erase: assert property (flash_mass_erase_o |-> erase_busy_o)
      else $error("erase without busy");
   a_prog_pass: assert property (fw_prog_i && !erase_busy_o |=> flash_prog_o &&
      flash_addr_o == $past(fw_addr_i) && flash_data_o == $past(fw_data_i))
      else $error("program request lost");
   a_div_steady: assert property (flash_mass_erase_o && $past(flash_mass_erase_o)
      |-> $stable(flash_erase_div_o))
      else $error("divider moved in erase");
endmodule // lockout_props

// [tb/jtag_host.sv]
// Debug host model driving the test access port
`timescale 1ns/1ps
module jtag_host (
   input  wire clk_i,
   input  wire tdo_i,
   output reg  tck_o = 1'b0,
   output reg  tms_o = 1'b0,
   output reg  tdi_o = 1'b0
);
   // ****************
   // Test clock, two system clocks low then high; it stands still between scans
   // ****************
   task step(input logic tms, input logic tdi, output logic tdo);
      begin
         tms_o = tms;
         tdi_o = tdi;
         repeat (2) @(posedge clk_i);
         #1 tdo = tdo_i;
         tck_o = 1'b1;
         repeat (2) @(posedge clk_i);
         #1 tck_o = 1'b0;
      end
   endtask
   // From Idle through one scan and back to Idle, where it stays
   task scan(input logic ir, input logic [31:0] v, input integer n,
             output logic [31:0] q);
      integer i;
      logic   b;
      begin
         q = 32'h0;
         // Leaves Test-Logic-Reset after a reset; harmless when already in Idle
         step(1'b0, tdi_o, b);
         step(1'b1, tdi_o, b);
         if (ir) step(1'b1, tdi_o, b);
         step(1'b0, tdi_o, b);
         step(1'b0, tdi_o, b);
         for (i = 0; i < n; i = i + 1) begin
            step(i == n - 1, v[i], b);
            q[i] = b;
         end
         step(1'b1, ~tdi_o, b);
         step(1'b0, ~tdi_o, b);
      end
   endtask
endmodule // jtag_host

// [tb/tb_top.sv]
// Top testbench for the lockout recovery block
`timescale 1ns/1ps
`include "lockout_recovery_map.vh"
module tb_top;
   logic        clk_i = 0, rstn_i = 0, trstn_i = 1, tck_i, tms_i, tdi_i;
   logic        fw_prog_i = 0, dbg_req_i = 0, flash_done_i = 0;
   logic [15:0] sec_word_i = `LR_SEC_SECURED, fw_addr_i = 0, fw_data_i = 0;
   logic        tdo_o, tdo_oe_n_o, dbg_grant_o, flash_mass_erase_o, flash_prog_o;
   logic        secured_o, erase_busy_o, erase_done_o;
   logic [6:0]  flash_erase_div_o;
   logic [15:0] flash_addr_o, flash_data_o;
   logic [31:0] q;
   integer      failures = 0, compares = 0, cycles = 0;
   logic        oe_seen = 1'b0;
   always #10 clk_i = ~clk_i;
   // Sampled off the launching edge so the settled enable is seen
   always @(negedge clk_i) begin
      if (!tdo_oe_n_o)
         oe_seen = 1'b1;
   end
   flash_lockout_recovery_jtag u_flash_lockout_recovery_jtag (
      .clk_i              (clk_i),
      .rstn_i             (rstn_i),
      .tck_i              (tck_i),
      .tms_i              (tms_i),
      .tdi_i              (tdi_i),
      .trstn_i            (trstn_i),
      .tdo_o              (tdo_o),
      .tdo_oe_n_o         (tdo_oe_n_o),
      .sec_word_i         (sec_word_i),
      .fw_prog_i          (fw_prog_i),
      .fw_addr_i          (fw_addr_i),
      .fw_data_i          (fw_data_i),
      .dbg_req_i          (dbg_req_i),
      .dbg_grant_o        (dbg_grant_o),
      .flash_done_i       (flash_done_i),
      .flash_mass_erase_o (flash_mass_erase_o),
      .flash_erase_div_o  (flash_erase_div_o),
      .flash_prog_o       (flash_prog_o),
      .flash_addr_o       (flash_addr_o),
      .flash_data_o       (flash_data_o),
      .secured_o          (secured_o),
      .erase_busy_o       (erase_busy_o),
      .erase_done_o       (erase_done_o)
   );
   jtag_host u_jtag_host (.clk_i(clk_i), .tdo_i(tdo_o), .tck_o(tck_i),
      .tms_o(tms_i), .tdi_o(tdi_i));
   // ****************
   // Shared tasks
   // ****************
   task results;
      begin
         $display("compares %0d failures %0d", compares, failures);
         if (failures == 0 && compares > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rst(input logic [15:0] w);
      begin
         sec_word_i = w;
         rstn_i = 0;
         repeat (2) @(posedge clk_i);
         #1 rstn_i = 1;
         repeat (2) @(posedge clk_i);
         #1;
      end
   endtask
   task ask_grant(input logic exp);
      begin
         u_jtag_host.scan(1, `LR_IR_CORE_DEBUG, 4, q);
         dbg_req_i = 1;
         repeat (3) @(posedge clk_i);
         #1 check(dbg_grant_o, exp);
         dbg_req_i = 0;
      end
   endtask
   // ****************
   // Scenarios
   // ****************
   task t_secure;
      begin
         rst(`LR_SEC_SECURED);
         check(secured_o, 1);
         ask_grant(0);
         trstn_i = 0;
         @(posedge clk_i);
         #1 trstn_i = 1;
         oe_seen = 1'b0;
         u_jtag_host.scan(0, 0, 32, q);
         check(q, `LR_IDCODE);
         check({oe_seen, tdo_oe_n_o}, 2'h3);
         $display("test secure done");
      end
   endtask
   task t_recover;
      begin
         rst(`LR_SEC_SECURED);
         u_jtag_host.scan(1, `LR_IR_RECOVERY, 4, q);
         repeat (8) @(posedge clk_i);
         #1 check(flash_mass_erase_o, 0);
         u_jtag_host.scan(0, 7'h55, 7, q);
         check(q, 32'h00000000);
         repeat (3) @(posedge clk_i);
         #1 check(flash_mass_erase_o, 1);
         check(flash_erase_div_o, 7'h55);
         repeat (20) @(posedge clk_i);
         #1 check(secured_o, 1);
         flash_done_i = 1;
         @(posedge clk_i);
         #1 flash_done_i = 0;
         @(posedge clk_i);
         #1 check({erase_done_o, flash_mass_erase_o}, 2'h2);
         rst(`LR_ERASED_WORD);
         check(secured_o, 0);
         ask_grant(1);
         $display("test recover done");
      end
   endtask
   task t_firmware;
      begin
         rst(`LR_SEC_SECURED);
         fw_addr_i = `LR_SEC_ADDR;
         fw_data_i = `LR_SEC_CLEAR;
         fw_prog_i = 1;
         @(posedge clk_i);
         #1 check(flash_prog_o, 1);
         check({flash_addr_o, flash_data_o}, {`LR_SEC_ADDR, `LR_SEC_CLEAR});
         fw_prog_i = 0;
         check(secured_o, 1);
         rst(`LR_SEC_CLEAR);
         check(secured_o, 0);
         $display("test firmware done");
      end
   endtask
   always @(posedge clk_i) begin
      cycles = cycles + 1;
      if (cycles == 6000) begin
         failures = failures + 1;
         results;
      end
   end
   initial begin
      t_secure;
      t_recover;
      t_firmware;
      results;
   end
endmodule // tb_top
bind flash_lockout_recovery_jtag lockout_props u_lockout_props (
   .clk_i              (clk_i),
   .rstn_i             (rstn_i),
   .sec_word_i         (sec_word_i),
   .fw_prog_i          (fw_prog_i),
   .fw_addr_i          (fw_addr_i),
   .fw_data_i          (fw_data_i),
   .dbg_grant_o        (dbg_grant_o),
   .flash_done_i       (flash_done_i),
   .flash_mass_erase_o (flash_mass_erase_o),
   .flash_erase_div_o  (flash_erase_div_o),
   .flash_prog_o       (flash_prog_o),
   .flash_addr_o       (flash_addr_o),
   .flash_data_o       (flash_data_o),
   .secured_o          (secured_o),
   .erase_busy_o       (erase_busy_o),
   .erase_done_o       (erase_done_o)
);
